// [pkg/igt_pkg.sv]
`default_nettype none
package igt_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int NUM_CH = 8;
  localparam int PARAM_W = 6;
  localparam int PULSE_W = 9;
  localparam logic [8:0] PULSE_MAX_MS = 9'h1F4;
  localparam int FKEY_COUNT = 6;
  localparam logic [5:0] FKEY_LAST = 6'h05;
  // ----------------------------------------
  // Register map and field layout
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [5:0] IN_CFG_WORD = 6'h00;
  localparam logic [5:0] OUT_CFG_WORD = 6'h08;
  localparam logic [5:0] STATUS_WORD = 6'h10;
  localparam int F_EN = 0;
  localparam int F_EDGE = 1;
  localparam int F_POL = 3;
  localparam int F_FUNC = 4;
  localparam int F_PARAM = 8;
  localparam int F_PULSE = 16;
  localparam int ST_RELAY = 8;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    IGT_EDGE_RISE = 2'h0,
    IGT_EDGE_FALL = 2'h1,
    IGT_EDGE_BOTH = 2'h2
  } igt_edge_t;
  typedef enum logic [1:0] {
    IGT_IN_CHANNEL_MUTE = 2'h0,
    IGT_IN_FUNCTION_KEY_INDICATOR = 2'h1,
    IGT_IN_TALKBACK_INPUT = 2'h2,
    IGT_IN_MONITOR_DIM = 2'h3
  } igt_in_func_t;
  typedef enum logic [1:0] {
    IGT_OUT_FADER_START = 2'h0,
    IGT_OUT_FUNCTION_KEY = 2'h1,
    IGT_OUT_TALKBACK_OUTPUT = 2'h2
  } igt_out_func_t;
endpackage
`default_nettype wire

// [verilog/igt_in_cond.sv]
`default_nettype none
module igt_in_cond (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Raw isolated level and millisecond tick
  input wire logic pin_in,
  input wire logic tick_in,
  // Conditioned level and edge pulses
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic samp;
    logic level;
    logic rise;
    logic fall;
  } igt_cond_t;

  igt_cond_t q;
  igt_cond_t next_q;

  // ----------------------------------------
  // Synchroniser and tick-sampled debounce
  // ----------------------------------------
  always_comb begin
    next_q = q;
    next_q.sync1 = pin_in;
    next_q.sync2 = q.sync1;
    next_q.rise = 1'b0;
    next_q.fall = 1'b0;
    if (tick_in) begin
      next_q.samp = q.sync2;
      // Level accepted only after two equal samples a tick apart
      if (q.sync2 == q.samp && q.sync2 != q.level) begin
        next_q.level = q.sync2;
        next_q.rise = q.sync2;
        next_q.fall = ~q.sync2;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level_out = q.level;
  assign rise_out = q.rise;
  assign fall_out = q.fall;
endmodule // igt_in_cond
`default_nettype wire

// [verilog/igt_port.sv]
// Notes on behaviour
// - An input channel whose enable is off never triggers its console function.
// - An input triggers only on its chosen transition: rising, falling or both.
// - Input polarity matters only when the input edge setting is both.
// - Input functions are channel mute 1-64, key indicator 1-6, talkback input, monitor dim A or B.
// - An output channel whose enable is off never operates its relay.
// - Output functions are fader start 1-64, function key 1-6 and talkback output.
// - An output operates its relay only on the chosen transition of its function.
// - Output polarity matters only when the output edge setting is both.
// - Each output has a pulse length of 0 to 500 ms.
// - With a pulse length set, the relay returns to its previous position when it runs out.
// - With no pulse length, the relay keeps its new position until the next trigger.
// - The stage-box port offers eight inputs and eight outputs; effects-tap lives on the local port.
// - An active output closes its relay contacts; an inactive one leaves them open.
//
// Added by the designer: the address map and the APB interface to the registers.
`default_nettype none
module igt_port #(
  parameter int NUM_CH = igt_pkg::NUM_CH,
  parameter int TICK_CYC = igt_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [igt_pkg::ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Isolated inputs and console function states
  input wire logic [NUM_CH-1:0] ISO_IN,
  input wire logic [63:0] FADER_START_IN,
  input wire logic [igt_pkg::FKEY_COUNT-1:0] FKEY_IN,
  input wire logic TALKBACK_IN,
  // Console function events
  output logic EVT_VALID_OUT,
  output logic [$clog2(NUM_CH)-1:0] EVT_CHAN_OUT,
  output logic [1:0] EVT_FUNC_OUT,
  output logic [igt_pkg::PARAM_W-1:0] EVT_PARAM_OUT,
  output logic EVT_LEVEL_OUT,
  // Relay contacts, high means closed
  output logic [NUM_CH-1:0] RELAY_OUT
);
  localparam int TW = $clog2(TICK_CYC);
  localparam int CW = $clog2(NUM_CH);

  typedef struct packed {
    logic [igt_pkg::PULSE_W-1:0] pulse;
    logic [igt_pkg::PARAM_W-1:0] param;
    logic [1:0] func;
    logic pol;
    logic [1:0] edge_sel;
    logic en;
  } igt_cfg_t;

  typedef struct packed {
    igt_cfg_t [NUM_CH-1:0] icfg;
    igt_cfg_t [NUM_CH-1:0] ocfg;
    logic [NUM_CH-1:0] pend;
    logic [NUM_CH-1:0] plev;
    logic [NUM_CH-1:0] relay;
    logic [NUM_CH-1:0] prev;
    logic [NUM_CH-1:0] src_prev;
    logic [NUM_CH-1:0][igt_pkg::PULSE_W-1:0] tmr;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic evt_valid;
    logic [CW-1:0] evt_chan;
    logic [1:0] evt_func;
    logic [igt_pkg::PARAM_W-1:0] evt_param;
    logic evt_level;
  } igt_state_t;

  igt_state_t q;
  igt_state_t next_q;
  logic [NUM_CH-1:0] in_lvl;
  logic [NUM_CH-1:0] in_rise;
  logic [NUM_CH-1:0] in_fall;

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : g_in
    igt_in_cond u_cond (
      .clk_in(SYS_CLK_IN),
      .rst_in(RST_IN),
      .pin_in(ISO_IN[g]),
      .tick_in(q.tick),
      .level_out(in_lvl[g]),
      .rise_out(in_rise[g]),
      .fall_out(in_fall[g])
    );
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      igt_pkg::IGT_EDGE_RISE: hit = r;
      igt_pkg::IGT_EDGE_FALL: hit = f;
      igt_pkg::IGT_EDGE_BOTH: hit = r | f;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [31:0] cfg_word(input igt_cfg_t c);
    logic [31:0] w;
    w = igt_pkg::WORD_ZERO;
    w[igt_pkg::F_EN] = c.en;
    w[igt_pkg::F_EDGE +: 2] = c.edge_sel;
    w[igt_pkg::F_POL] = c.pol;
    w[igt_pkg::F_FUNC +: 2] = c.func;
    w[igt_pkg::F_PARAM +: igt_pkg::PARAM_W] = c.param;
    w[igt_pkg::F_PULSE +: igt_pkg::PULSE_W] = c.pulse;
    return w;
  endfunction

  function automatic igt_cfg_t word_cfg(input logic [31:0] w, input logic has_pulse);
    igt_cfg_t c;
    c.en = w[igt_pkg::F_EN];
    c.edge_sel = w[igt_pkg::F_EDGE +: 2];
    c.pol = w[igt_pkg::F_POL];
    c.func = w[igt_pkg::F_FUNC +: 2];
    c.param = w[igt_pkg::F_PARAM +: igt_pkg::PARAM_W];
    c.pulse = '0;
    if (has_pulse) begin
      c.pulse = w[igt_pkg::F_PULSE +: igt_pkg::PULSE_W];
      if (c.pulse > igt_pkg::PULSE_MAX_MS) begin
        c.pulse = igt_pkg::PULSE_MAX_MS;
      end
    end
    return c;
  endfunction

  // Current state of the console function feeding an output
  function automatic logic out_src(input igt_cfg_t c, input logic [63:0] fdr,
                                   input logic [igt_pkg::FKEY_COUNT-1:0] fk, input logic tb);
    logic s;
    s = 1'b0;
    unique case (c.func)
      igt_pkg::IGT_OUT_FADER_START: s = fdr[c.param];
      igt_pkg::IGT_OUT_FUNCTION_KEY: s = (c.param <= igt_pkg::FKEY_LAST) ? fk[c.param[2:0]] : 1'b0;
      igt_pkg::IGT_OUT_TALKBACK_OUTPUT: s = tb;
      default: s = 1'b0;
    endcase
    return s;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic access;
    logic [5:0] word;
    logic found;
    logic src;
    logic o_hit;
    logic in_hit;
    access = PSEL_IN & PENABLE_IN & ~q.pready;
    word = PADDR_IN[igt_pkg::ADDR_W-1:2];
    found = 1'b0;
    src = 1'b0;
    o_hit = 1'b0;
    in_hit = 1'b0;
    next_q = q;

    // Millisecond tick
    next_q.tick = 1'b0;
    next_q.tick_cnt = q.tick_cnt + 1'b1;
    if (q.tick_cnt == TW'(TICK_CYC - 1)) begin
      next_q.tick_cnt = '0;
      next_q.tick = 1'b1;
    end

    // APB access, one wait state
    next_q.pready = access;
    next_q.pslverr = 1'b0;
    next_q.prdata = igt_pkg::WORD_ZERO;
    if (access) begin
      if (PADDR_IN[1:0] != 2'h0) begin
        next_q.pslverr = 1'b1;
      end else if (word == igt_pkg::STATUS_WORD) begin
        next_q.prdata[NUM_CH-1:0] = in_lvl;
        next_q.prdata[igt_pkg::ST_RELAY +: NUM_CH] = q.relay;
      end else if (word >= igt_pkg::IN_CFG_WORD && word < igt_pkg::IN_CFG_WORD + 6'(NUM_CH)) begin
        next_q.prdata = cfg_word(q.icfg[CW'(word - igt_pkg::IN_CFG_WORD)]);
        if (PWRITE_IN) begin
          next_q.icfg[CW'(word - igt_pkg::IN_CFG_WORD)] = word_cfg(PWDATA_IN, 1'b0);
        end
      end else if (word >= igt_pkg::OUT_CFG_WORD && word < igt_pkg::OUT_CFG_WORD + 6'(NUM_CH)) begin
        next_q.prdata = cfg_word(q.ocfg[CW'(word - igt_pkg::OUT_CFG_WORD)]);
        if (PWRITE_IN) begin
          next_q.ocfg[CW'(word - igt_pkg::OUT_CFG_WORD)] = word_cfg(PWDATA_IN, 1'b1);
        end
      end else begin
        next_q.pslverr = 1'b1;
      end
      if (PWRITE_IN) begin
        next_q.prdata = igt_pkg::WORD_ZERO;
      end
    end

    // Issue the lowest pending input event
    next_q.evt_valid = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (q.pend[i] && !found) begin
        found = 1'b1;
        next_q.pend[i] = 1'b0;
        next_q.evt_valid = 1'b1;
        next_q.evt_chan = CW'(i);
        next_q.evt_func = q.icfg[i].func;
        next_q.evt_param = q.icfg[i].param;
        next_q.evt_level = q.plev[i];
      end
    end

    // New input triggers; a new trigger wins over the issue above
    for (int i = 0; i < NUM_CH; i++) begin
      in_hit = edge_hit(q.icfg[i].edge_sel, in_rise[i], in_fall[i]);
      if (q.icfg[i].en && in_hit) begin
        next_q.pend[i] = 1'b1;
        unique case (q.icfg[i].edge_sel)
          igt_pkg::IGT_EDGE_BOTH: next_q.plev[i] = in_lvl[i] ^ q.icfg[i].pol;
          igt_pkg::IGT_EDGE_RISE: next_q.plev[i] = 1'b1;
          default: next_q.plev[i] = 1'b0;
        endcase
      end
    end

    // Relay outputs
    for (int i = 0; i < NUM_CH; i++) begin
      src = out_src(q.ocfg[i], FADER_START_IN, FKEY_IN, TALKBACK_IN);
      next_q.src_prev[i] = src;
      o_hit = edge_hit(q.ocfg[i].edge_sel, src & ~q.src_prev[i], ~src & q.src_prev[i]);
      if (!q.ocfg[i].en) begin
        next_q.relay[i] = 1'b0;
        next_q.tmr[i] = '0;
      end else if (o_hit) begin
        if (q.ocfg[i].edge_sel == igt_pkg::IGT_EDGE_BOTH) begin
          next_q.relay[i] = src ^ q.ocfg[i].pol;
        end else begin
          next_q.relay[i] = ~((q.tmr[i] != '0) ? q.prev[i] : q.relay[i]);
        end
        if (q.ocfg[i].pulse != '0) begin
          if (q.tmr[i] == '0) begin
            next_q.prev[i] = q.relay[i];
          end
          // One extra tick so a pulse never ends before its full length
          next_q.tmr[i] = q.ocfg[i].pulse + 1'b1;
        end
      end else if (q.tick && q.tmr[i] != '0) begin
        next_q.tmr[i] = q.tmr[i] - 1'b1;
        if (q.tmr[i] == igt_pkg::PULSE_W'(1)) begin
          next_q.relay[i] = q.prev[i];
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign PRDATA_OUT = q.prdata;
  assign PREADY_OUT = q.pready;
  assign PSLVERR_OUT = q.pslverr;
  assign EVT_VALID_OUT = q.evt_valid;
  assign EVT_CHAN_OUT = q.evt_chan;
  assign EVT_FUNC_OUT = q.evt_func;
  assign EVT_PARAM_OUT = q.evt_param;
  assign EVT_LEVEL_OUT = q.evt_level;
  assign RELAY_OUT = q.relay;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_in_enable: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    $rose(q.pend[0]) |-> $past(q.icfg[0].en))
    else $error("disabled input raised an event");
  chk_in_edge: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    $rose(q.pend[0]) |-> $past(edge_hit(q.icfg[0].edge_sel, in_rise[0], in_fall[0])))
    else $error("input event on wrong edge");
  chk_in_polarity: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    $rose(q.pend[0]) && q.icfg[0].edge_sel == igt_pkg::IGT_EDGE_BOTH
      |-> q.plev[0] == ($past(in_lvl[0]) ^ q.icfg[0].pol))
    else $error("both-edge level ignores polarity");
  chk_evt_issue: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    q.pend[0] |=> EVT_VALID_OUT && EVT_CHAN_OUT == '0 && EVT_FUNC_OUT == $past(q.icfg[0].func))
    else $error("pending event not issued");
  chk_out_disabled: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    !q.ocfg[0].en |=> !RELAY_OUT[0])
    else $error("disabled relay closed");
  chk_pulse_max: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    q.ocfg[0].pulse <= igt_pkg::PULSE_MAX_MS && q.tmr[0] <= igt_pkg::PULSE_MAX_MS + 9'h001)
    else $error("pulse length above limit");
  chk_pulse_end: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    q.ocfg[1].en && q.tick && q.tmr[1] == igt_pkg::PULSE_W'(1) ##1 $stable(q.src_prev[1])
      |-> RELAY_OUT[1] == $past(q.prev[1]) && q.tmr[1] == '0)
    else $error("relay did not return after pulse");
  chk_latch_hold: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    q.ocfg[0].en && q.tmr[0] == '0 && $stable(q.src_prev[0]) ##1 $stable(q.src_prev[0])
      && $stable(q.ocfg[0]) |-> $stable(RELAY_OUT[0]))
    else $error("latched relay moved without trigger");
  chk_apb_ready: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("APB answer not one cycle");
  cov_event: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN) EVT_VALID_OUT);
  cov_pulse: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    q.tmr[1] == igt_pkg::PULSE_W'(1) && q.tick);
  cov_write: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    PREADY_OUT && PWRITE_IN && !PSLVERR_OUT);
endmodule // igt_port
`default_nettype wire

// [tb/igt_ext_equip.sv]
`default_nettype none
module igt_ext_equip (
  // Clock
  input wire logic clk_in,
  // Contact levels the equipment should settle at
  input wire logic [7:0] level_in,
  // Isolated input lines seen by the port
  output logic [7:0] iso_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held = 8'h00;
  logic [7:0] chg = 8'h00;
  logic [2:0] bounce = 3'h0;
  initial iso_out = 8'h00;
  // Real contacts chatter for a few cycles after every change
  always @(posedge clk_in) begin
    if (level_in != held) begin
      held <= level_in;
      chg <= level_in ^ held;
      bounce <= 3'h6;
      iso_out <= iso_out ^ (level_in ^ held);
    end else if (bounce != 3'h0) begin
      bounce <= bounce - 3'h1;
      iso_out <= (bounce == 3'h1) ? held : iso_out ^ chg;
    end
  end
endmodule // igt_ext_equip
`default_nettype wire

// [tb/igt_port_tb_top.sv]
`default_nettype none
module igt_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int TICK = 20;
  localparam logic [1:0] RI = igt_pkg::IGT_EDGE_RISE;
  localparam logic [1:0] FA = igt_pkg::IGT_EDGE_FALL;
  localparam logic [1:0] BO = igt_pkg::IGT_EDGE_BOTH;
  typedef struct packed {
    logic [31:0] cfg;
    logic is_out;
    logic lvl;
    logic hit;
    logic val;
  } igt_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, evt_valid, evt_level, err, got;
  logic [7:0] iso, relay;
  logic [7:0] want = 8'h00;
  logic [63:0] fader = 64'h0;
  logic [5:0] fkey = 6'h00;
  logic tb = 1'b0;
  logic [2:0] evt_chan;
  logic [1:0] evt_func;
  logic [5:0] evt_param;
  logic [31:0] rd;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  igt_row_t rows[14];
  igt_row_t r;
  always #20 clk = ~clk;
  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  igt_ext_equip FAR (.clk_in(clk), .level_in(want), .iso_out(iso));
  igt_port #(.NUM_CH(8), .TICK_CYC(TICK)) DUT (
    .SYS_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .ISO_IN(iso), .FADER_START_IN(fader), .FKEY_IN(fkey), .TALKBACK_IN(tb),
    .EVT_VALID_OUT(evt_valid), .EVT_CHAN_OUT(evt_chan), .EVT_FUNC_OUT(evt_func),
    .EVT_PARAM_OUT(evt_param), .EVT_LEVEL_OUT(evt_level), .RELAY_OUT(relay));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] cfg(input logic en, input logic [1:0] ed, input logic pol,
      input logic [1:0] fn, input logic [5:0] prm, input logic [8:0] pl);
    cfg = {7'h00, pl, 2'h0, prm, 2'h0, fn, pol, ed, en};
  endfunction
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_evt();
    got = 1'b0;
    for (int n = 0; n < 80 && got == 1'b0; n++) begin
      @(posedge clk);
      if (evt_valid === 1'b1) begin
        got = 1'b1;
      end
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    rows = '{'{cfg(1, RI, 0, 0, 6'h3F, 0), 1'b0, 1'b1, 1'b1, 1'b1}, '{cfg(1, RI, 0, 1, 6'h05, 0), 1'b0, 1'b0, 1'b0, 1'b0},
      '{cfg(1, FA, 0, 2, 6'h00, 0), 1'b0, 1'b1, 1'b0, 1'b0}, '{cfg(1, FA, 0, 3, 6'h01, 0), 1'b0, 1'b0, 1'b1, 1'b0},
      '{cfg(1, BO, 0, 0, 6'h00, 0), 1'b0, 1'b1, 1'b1, 1'b1}, '{cfg(1, BO, 1, 1, 6'h02, 0), 1'b0, 1'b0, 1'b1, 1'b1},
      '{cfg(0, BO, 0, 0, 6'h00, 0), 1'b0, 1'b1, 1'b0, 1'b0}, '{cfg(1, FA, 1, 1, 6'h00, 0), 1'b0, 1'b0, 1'b1, 1'b0},
      '{cfg(1, RI, 1, 2, 6'h00, 0), 1'b0, 1'b1, 1'b1, 1'b1}, '{cfg(1, BO, 0, 0, 6'h3F, 0), 1'b1, 1'b1, 1'b0, 1'b1},
      '{cfg(1, BO, 0, 1, 6'h00, 0), 1'b1, 1'b0, 1'b0, 1'b0}, '{cfg(1, BO, 1, 2, 6'h00, 0), 1'b1, 1'b1, 1'b0, 1'b0},
      '{cfg(1, BO, 1, 1, 6'h00, 0), 1'b1, 1'b0, 1'b0, 1'b1}, '{cfg(0, BO, 0, 1, 6'h00, 0), 1'b1, 1'b1, 1'b0, 1'b0}};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(relay === 8'h00 && evt_valid === 1'b0, "outputs after reset");
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, r.is_out ? 8'h20 : 8'h00, r.cfg);
      @(posedge clk);
      if (r.is_out) begin
        fkey[0] <= r.lvl;
        tb <= r.lvl;
        fader[63] <= r.lvl;
        repeat (4) @(posedge clk);
        chk(relay[0] === r.val, "relay level in both-edge mode");
      end else begin
        want[0] <= r.lvl;
        wait_evt();
        chk(got === r.hit, "event presence");
        if (r.hit) begin
          chk({evt_chan, evt_func, evt_param, evt_level} === {3'h0, r.cfg[5:4], r.cfg[13:8], r.val}, "event fields");
        end
      end
    end
    apb(1'b1, 8'h1C, cfg(1, BO, 1, 3, 6'h3F, 0));
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd === cfg(1, BO, 1, 3, 6'h3F, 0) && err === 1'b0, "last input config readback");
    apb(1'b1, 8'h3C, cfg(0, RI, 0, 0, 6'h00, 9'h1FF));
    apb(1'b0, 8'h3C, 32'h0);
    chk(rd[24:16] === igt_pkg::PULSE_MAX_MS, "pulse length ceiling");
    apb(1'b0, 8'h44, 32'h0);
    chk(err === 1'b1, "unmapped read accepted");
    apb(1'b1, 8'h24, cfg(1, RI, 0, 1, 6'h01, 9'h003));
    fkey[1] <= 1'b1;
    repeat (4) @(posedge clk);
    chk(relay[1] === 1'b1, "pulse start");
    repeat (50) @(posedge clk);
    chk(relay[1] === 1'b1, "pulse ended early");
    repeat (40) @(posedge clk);
    chk(relay[1] === 1'b0, "pulse did not end");
    fkey[1] <= 1'b0;
    repeat (4) @(posedge clk);
    chk(relay[1] === 1'b0, "falling edge in rising mode");
    apb(1'b1, 8'h28, cfg(1, FA, 0, 2, 6'h00, 0));
    tb <= 1'b0;
    repeat (200) @(posedge clk);
    chk(relay[2] === 1'b1, "latched relay released");
    apb(1'b1, 8'h04, cfg(1, BO, 0, 0, 6'h00, 0));
    want[1] <= 1'b1;
    repeat (3) @(posedge clk);
    want[1] <= 1'b0;
    wait_evt();
    chk(got === 1'b0, "short glitch passed");
    apb(1'b0, 8'h40, 32'h0);
    chk(rd[15:0] === 16'h0401, "status levels");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(relay === 8'h00, "relays after second reset");
    apb(1'b0, 8'h28, 32'h0);
    chk(rd === 32'h0000_0000, "config after second reset");
    tally_and_finish();
  end
endmodule // igt_port_tb_top
`default_nettype wire
